// ### design/bsl_defs.svh
// strap field widths, pinout codes and reset values for the boot strap latch
// Overview of operation
// R1: multiplexed strap pins act as configuration inputs only while device reset is active
// R2: every strap pin level is stored in the configuration latch at reset release
// R3: board keeps multiplexed strap levels valid through release; later changes are ignored
// R4: pci enable strap is a dedicated input, captured at reset release
// R5: board holds the pci enable strap at its level after release too
// R6: capture on low-to-high of the AND of both active-low reset inputs
// R7: boot mode comes from four boot select bits plus the quick start bit
// R8: three multiplier select bits choose the pll factor used in quick start
// R9: pinout select decodes 000 none, 010 async mode 2, 101 nand mode 5
// R10: pinout select changes pin assignment only, never the memory controller
// R11: width strap sets region 2 default width: 0 is 8-bit, 1 is 16-bit
// R12: board sets pinout select to match the width strap
// R13: captured pci enable disables pci pins at 0, enables them at 1
// R14: byte order strap selects big-endian at 0, little-endian at 1
// R15: captured values stay constant between capture events
`ifndef BSL_DEFS_SVH
`define BSL_DEFS_SVH

`define BSL_BOOT_W 4
`define BSL_MULT_W 3
`define BSL_PINOUT_W 3
`define BSL_PINOUT_NONE 3'h0
`define BSL_PINOUT_ASYNC2 3'h2
`define BSL_PINOUT_NAND5 3'h5
`define BSL_CS2_8BIT 1'h0
`define BSL_CS2_16BIT 1'h1
`define BSL_BIG_ENDIAN 1'h0
`define BSL_LITTLE_ENDIAN 1'h1
`define BSL_CFG_RESET 14'h0000

`endif

// ### design/bsl_pkg.sv
// types shared by the boot strap latch modules
package bsl_pkg;
    typedef struct packed {
        logic [3:0] boot_select;
        logic quick_start;
        logic [2:0] start_multiplier_select;
        logic [2:0] ext_bus_pinout_select;
        logic cs2_width;
        logic pci_enable;
        logic byte_order;
    } bsl_cfg_t;

    typedef enum logic [3:0] {
        BSL_PIN_NONE = 4'h1,
        BSL_PIN_ASYNC2 = 4'h2,
        BSL_PIN_NAND5 = 4'h4,
        BSL_PIN_UNDEF = 4'h8
    } bsl_pinout_t;
endpackage : bsl_pkg

// ### design/bsl_cfg_if.sv
// carrier between the latch and its decoder
`timescale 1ns/1ps
`default_nettype none
interface bsl_cfg_if;
    bsl_pkg::bsl_cfg_t cfg;
    bsl_pkg::bsl_pinout_t pinout;
    logic mult_applied;
    modport latch (output cfg, input pinout, input mult_applied);
    modport decode (input cfg, output pinout, output mult_applied);
endinterface : bsl_cfg_if
`default_nettype wire

// ### design/bsl_decode.sv
// decoder of the captured strap configuration
`timescale 1ns/1ps
`default_nettype none
`include "bsl_defs.svh"
module bsl_decode (
    bsl_cfg_if.decode cfg_bus
);
    // ---------------------------------------------
    // pinout decode
    // ---------------------------------------------
    function automatic bsl_pkg::bsl_pinout_t pinout_of(input logic [2:0] sel);
        bsl_pkg::bsl_pinout_t res;
        res = bsl_pkg::BSL_PIN_UNDEF;
        if (sel == `BSL_PINOUT_NONE) begin
            res = bsl_pkg::BSL_PIN_NONE;
        end else if (sel == `BSL_PINOUT_ASYNC2) begin
            res = bsl_pkg::BSL_PIN_ASYNC2;
        end else if (sel == `BSL_PINOUT_NAND5) begin
            res = bsl_pkg::BSL_PIN_NAND5;
        end
        return res;
    endfunction : pinout_of

    // pin assignment only; no controller setting derives from it
    assign cfg_bus.pinout = pinout_of(cfg_bus.cfg.ext_bus_pinout_select); // R9 R10
    // multiplier is only applied in quick start boot
    assign cfg_bus.mult_applied = cfg_bus.cfg.quick_start; // R8
endmodule : bsl_decode
`default_nettype wire

// ### design/boot_strap_latch.sv
// boot strap latch: captures configuration straps at reset release
`timescale 1ns/1ps
`default_nettype none
`include "bsl_defs.svh"
module boot_strap_latch (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic RESET_N_I,
    input wire logic POR_N_I,
    input wire logic [3:0] BOOT_SELECT_I,
    input wire logic QUICK_START_STRAP_I,
    input wire logic [2:0] START_MULTIPLIER_SELECT_I,
    input wire logic [2:0] EXT_BUS_PINOUT_SELECT_I,
    input wire logic CS2_WIDTH_STRAP_I,
    input wire logic PCI_ENABLE_STRAP_I,
    input wire logic BYTE_ORDER_STRAP_I,
    output logic STRAP_PHASE_O,
    output logic CONFIG_VALID_O,
    output logic [3:0] BOOT_MODE_O,
    output logic QUICK_START_O,
    output logic [2:0] PLL_MULT_SELECT_O,
    output logic PLL_MULT_APPLY_O,
    output logic NO_ASYNC_PORT_O,
    output logic PINOUT_ASYNC2_O,
    output logic PINOUT_NAND5_O,
    output logic PINOUT_UNDEF_O,
    output logic CS2_WIDE_O,
    output logic PCI_PINS_EN_O,
    output logic LITTLE_ENDIAN_O
);
    // ---------------------------------------------
    // release detection
    // ---------------------------------------------
    logic reset_and;
    logic reset_and_prev;
    logic release_edge;
    bsl_pkg::bsl_cfg_t strap_now;
    bsl_pkg::bsl_cfg_t boot_config_latch;
    bsl_pkg::bsl_cfg_t next_boot_config_latch;
    logic config_valid;

    assign reset_and = RESET_N_I & POR_N_I; // R6
    assign release_edge = reset_and & ~reset_and_prev; // R6

    // pci enable arrives on its own dedicated pin
    assign strap_now = '{boot_select: BOOT_SELECT_I,
                         quick_start: QUICK_START_STRAP_I,
                         start_multiplier_select: START_MULTIPLIER_SELECT_I,
                         ext_bus_pinout_select: EXT_BUS_PINOUT_SELECT_I,
                         cs2_width: CS2_WIDTH_STRAP_I,
                         pci_enable: PCI_ENABLE_STRAP_I, // R4
                         byte_order: BYTE_ORDER_STRAP_I};

    // later pin activity never reaches the latch
    assign next_boot_config_latch = release_edge ? strap_now : boot_config_latch; // R2 R15

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            reset_and_prev <= 1'b0;
        end else begin
            reset_and_prev <= reset_and;
        end
    end

    // ---------------------------------------------
    // configuration latch
    // ---------------------------------------------
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            boot_config_latch <= `BSL_CFG_RESET;
            config_valid <= 1'b0;
        end else begin
            boot_config_latch <= next_boot_config_latch; // R2 R15
            config_valid <= config_valid | release_edge;
        end
    end

    bsl_cfg_if cfg_bus ();
    assign cfg_bus.cfg = boot_config_latch;

    bsl_decode u_decode (
        .cfg_bus(cfg_bus)
    );

    // ---------------------------------------------
    // registered outputs
    // ---------------------------------------------
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            STRAP_PHASE_O <= 1'b1;
            CONFIG_VALID_O <= 1'b0;
            BOOT_MODE_O <= 4'h0;
            QUICK_START_O <= 1'b0;
            PLL_MULT_SELECT_O <= 3'h0;
            PLL_MULT_APPLY_O <= 1'b0;
            NO_ASYNC_PORT_O <= 1'b0;
            PINOUT_ASYNC2_O <= 1'b0;
            PINOUT_NAND5_O <= 1'b0;
            PINOUT_UNDEF_O <= 1'b0;
            CS2_WIDE_O <= 1'b0;
            PCI_PINS_EN_O <= 1'b0;
            LITTLE_ENDIAN_O <= 1'b0;
        end else begin
            STRAP_PHASE_O <= ~reset_and; // R1
            CONFIG_VALID_O <= config_valid;
            BOOT_MODE_O <= boot_config_latch.boot_select; // R7
            QUICK_START_O <= boot_config_latch.quick_start; // R7
            PLL_MULT_SELECT_O <= boot_config_latch.start_multiplier_select; // R8
            PLL_MULT_APPLY_O <= cfg_bus.mult_applied; // R8
            NO_ASYNC_PORT_O <= cfg_bus.pinout == bsl_pkg::BSL_PIN_NONE; // R9
            PINOUT_ASYNC2_O <= cfg_bus.pinout == bsl_pkg::BSL_PIN_ASYNC2; // R9
            PINOUT_NAND5_O <= cfg_bus.pinout == bsl_pkg::BSL_PIN_NAND5; // R9
            PINOUT_UNDEF_O <= cfg_bus.pinout == bsl_pkg::BSL_PIN_UNDEF;
            CS2_WIDE_O <= boot_config_latch.cs2_width == `BSL_CS2_16BIT; // R11
            PCI_PINS_EN_O <= boot_config_latch.pci_enable; // R13
            LITTLE_ENDIAN_O <= boot_config_latch.byte_order == `BSL_LITTLE_ENDIAN; // R14
        end
    end

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    property p_capture;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        release_edge |=> boot_config_latch == $past(strap_now);
    endproperty
    a_capture: assert property (p_capture) else $error("strap capture wrong"); // R2

    property p_hold;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        !release_edge |=> $stable(boot_config_latch);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed without release"); // R15

    property p_edge;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(RESET_N_I & POR_N_I) |-> release_edge;
    endproperty
    a_edge: assert property (p_edge) else $error("release edge missed"); // R6

    property p_phase;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        1'b1 |=> STRAP_PHASE_O == !$past(RESET_N_I & POR_N_I);
    endproperty
    a_phase: assert property (p_phase) else $error("strap phase wrong"); // R1

    property p_boot;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        release_edge |=> ##1 BOOT_MODE_O == $past(BOOT_SELECT_I, 2)
            && QUICK_START_O == $past(QUICK_START_STRAP_I, 2);
    endproperty
    a_boot: assert property (p_boot) else $error("boot mode wrong"); // R7

    property p_mult;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        release_edge |=> ##1 PLL_MULT_APPLY_O == $past(QUICK_START_STRAP_I, 2)
            && PLL_MULT_SELECT_O == $past(START_MULTIPLIER_SELECT_I, 2);
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier select wrong"); // R8

    property p_pinout;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        release_edge |=> ##1
            NO_ASYNC_PORT_O == ($past(EXT_BUS_PINOUT_SELECT_I, 2) == 3'h0)
            && PINOUT_ASYNC2_O == ($past(EXT_BUS_PINOUT_SELECT_I, 2) == 3'h2)
            && PINOUT_NAND5_O == ($past(EXT_BUS_PINOUT_SELECT_I, 2) == 3'h5);
    endproperty
    a_pinout: assert property (p_pinout) else $error("pinout decode wrong"); // R9

    property p_cs2;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        release_edge |=> ##1 CS2_WIDE_O == $past(CS2_WIDTH_STRAP_I, 2);
    endproperty
    a_cs2: assert property (p_cs2) else $error("region 2 width wrong"); // R11

    property p_pci;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        release_edge |=> ##1 PCI_PINS_EN_O == $past(PCI_ENABLE_STRAP_I, 2);
    endproperty
    a_pci: assert property (p_pci) else $error("pci enable wrong"); // R4 R13

    property p_endian;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        release_edge |=> ##1 LITTLE_ENDIAN_O == $past(BYTE_ORDER_STRAP_I, 2);
    endproperty
    a_endian: assert property (p_endian) else $error("byte order wrong"); // R14

    property p_undef;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        release_edge |=> ##1 PINOUT_UNDEF_O ==
            !($past(EXT_BUS_PINOUT_SELECT_I, 2) inside {3'h0, 3'h2, 3'h5});
    endproperty
    a_undef: assert property (p_undef) else $error("undefined pinout flag wrong"); // R9

    property p_onehot;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        CONFIG_VALID_O |-> $onehot({NO_ASYNC_PORT_O, PINOUT_ASYNC2_O, PINOUT_NAND5_O,
            PINOUT_UNDEF_O});
    endproperty
    a_onehot: assert property (p_onehot) else $error("pinout flags not exclusive"); // R9

    property p_pci_pin;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        release_edge |=> boot_config_latch.pci_enable == $past(PCI_ENABLE_STRAP_I);
    endproperty
    a_pci_pin: assert property (p_pci_pin) else $error("pci strap capture wrong"); // R4

    property p_valid_set;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        release_edge |=> ##1 CONFIG_VALID_O;
    endproperty
    a_valid_set: assert property (p_valid_set) else $error("valid flag not set"); // R2

    property p_valid_hold;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        CONFIG_VALID_O |=> CONFIG_VALID_O;
    endproperty
    a_valid_hold: assert property (p_valid_hold) else $error("valid flag dropped"); // R15

    property p_out_hold;
        @(posedge SYS_CLK_I) disable iff (RST_I)
        CONFIG_VALID_O && !release_edge |=> ##1 $stable(BOOT_MODE_O)
            && $stable(PLL_MULT_SELECT_O) && $stable(CS2_WIDE_O)
            && $stable(PCI_PINS_EN_O) && $stable(LITTLE_ENDIAN_O);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("outputs moved without release"); // R15
endmodule : boot_strap_latch
`default_nettype wire

// ### bench/bsl_board_model.sv
// board strap resistors and the pin traffic that follows reset release
`timescale 1ns/1ps
`default_nettype none
module bsl_board_model (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic por_n_i,
    input wire bsl_pkg::bsl_cfg_t strap_i,
    output bsl_pkg::bsl_cfg_t pins_o
);
    // ----------------------------------------
    // reset tracking
    // ----------------------------------------
    logic in_reset = 1'h1;
    always_ff @(posedge clk_i) begin
        in_reset <= !(reset_n_i && por_n_i);
    end
    // ----------------------------------------
    // pin levels
    // ----------------------------------------
    // straps stay valid through the release edge, shared pins then carry other traffic
    // strap combination chosen by the bench keeps width and pinout matched
    // dedicated pci enable strap is held at its level at all times
    assign pins_o = in_reset ? strap_i : {~strap_i[13:2], strap_i[1], ~strap_i[0]};
endmodule : bsl_board_model
`default_nettype wire

// ### bench/testbench.sv
// self-checking testbench for the boot strap latch
`timescale 1ns/1ps
`default_nettype none
`include "bsl_defs.svh"
module testbench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic SYS_CLK_I = 1'h0;
    logic RST_I = 1'h1;
    logic RESET_N_I = 1'h0;
    logic POR_N_I = 1'h0;
    logic STRAP_PHASE_O, CONFIG_VALID_O, QUICK_START_O, PLL_MULT_APPLY_O, NO_ASYNC_PORT_O;
    logic PINOUT_ASYNC2_O, PINOUT_NAND5_O, PINOUT_UNDEF_O, CS2_WIDE_O, PCI_PINS_EN_O;
    logic LITTLE_ENDIAN_O;
    logic [3:0] BOOT_MODE_O;
    logic [2:0] PLL_MULT_SELECT_O;
    logic [15:0] seen;
    bsl_pkg::bsl_cfg_t strap = '0;
    bsl_pkg::bsl_cfg_t pins;
    bsl_pkg::bsl_cfg_t cases [4];
    int n_errors = 0;
    int total_checks = 0;
    assign seen = {BOOT_MODE_O, QUICK_START_O, PLL_MULT_SELECT_O, PLL_MULT_APPLY_O,
        NO_ASYNC_PORT_O, PINOUT_ASYNC2_O, PINOUT_NAND5_O, PINOUT_UNDEF_O, CS2_WIDE_O,
        PCI_PINS_EN_O, LITTLE_ENDIAN_O};
    initial begin
        forever #5 SYS_CLK_I = ~SYS_CLK_I;
    end
    // ----------------------------------------
    // instances
    // ----------------------------------------
    bsl_board_model u_board (.clk_i(SYS_CLK_I), .reset_n_i(RESET_N_I), .por_n_i(POR_N_I),
        .strap_i(strap), .pins_o(pins));
    boot_strap_latch u_dut (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .RESET_N_I(RESET_N_I),
        .POR_N_I(POR_N_I), .BOOT_SELECT_I(pins.boot_select),
        .QUICK_START_STRAP_I(pins.quick_start),
        .START_MULTIPLIER_SELECT_I(pins.start_multiplier_select),
        .EXT_BUS_PINOUT_SELECT_I(pins.ext_bus_pinout_select),
        .CS2_WIDTH_STRAP_I(pins.cs2_width), .PCI_ENABLE_STRAP_I(pins.pci_enable),
        .BYTE_ORDER_STRAP_I(pins.byte_order), .STRAP_PHASE_O(STRAP_PHASE_O),
        .CONFIG_VALID_O(CONFIG_VALID_O), .BOOT_MODE_O(BOOT_MODE_O),
        .QUICK_START_O(QUICK_START_O), .PLL_MULT_SELECT_O(PLL_MULT_SELECT_O),
        .PLL_MULT_APPLY_O(PLL_MULT_APPLY_O), .NO_ASYNC_PORT_O(NO_ASYNC_PORT_O),
        .PINOUT_ASYNC2_O(PINOUT_ASYNC2_O), .PINOUT_NAND5_O(PINOUT_NAND5_O),
        .PINOUT_UNDEF_O(PINOUT_UNDEF_O), .CS2_WIDE_O(CS2_WIDE_O),
        .PCI_PINS_EN_O(PCI_PINS_EN_O), .LITTLE_ENDIAN_O(LITTLE_ENDIAN_O));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] expv(input bsl_pkg::bsl_cfg_t c);
        logic [2:0] p;
        p = c.ext_bus_pinout_select;
        return {c.boot_select, c.quick_start, c.start_multiplier_select, c.quick_start,
            p == `BSL_PINOUT_NONE, p == `BSL_PINOUT_ASYNC2, p == `BSL_PINOUT_NAND5,
            !(p inside {`BSL_PINOUT_NONE, `BSL_PINOUT_ASYNC2, `BSL_PINOUT_NAND5}),
            c.cs2_width == `BSL_CS2_16BIT, c.pci_enable, c.byte_order == `BSL_LITTLE_ENDIAN};
    endfunction : expv
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic capture(input bsl_pkg::bsl_cfg_t c, input logic by_por);
        @(posedge SYS_CLK_I);
        strap <= c;
        if (by_por) POR_N_I <= 1'h0;
        else RESET_N_I <= 1'h0;
        repeat (2) @(posedge SYS_CLK_I);
        #1 check({15'h0, STRAP_PHASE_O}, 16'h1);
        @(posedge SYS_CLK_I);
        RESET_N_I <= 1'h1;
        POR_N_I <= 1'h1;
        repeat (2) @(posedge SYS_CLK_I);
        #1 check(seen, expv(c));
        check({15'h0, CONFIG_VALID_O}, 16'h1);
        repeat (6) @(posedge SYS_CLK_I);
        #1 check({15'h0, STRAP_PHASE_O}, 16'h0);
        check(seen, expv(c));
    endtask : capture
    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge SYS_CLK_I);
        n_errors++;
        wrap_up();
    end
    initial begin
        cases[0] = '{4'hA, 1'h1, 3'h5, 3'h2, 1'h1, 1'h1, 1'h0};
        cases[1] = '{4'h5, 1'h0, 3'h2, 3'h5, 1'h0, 1'h0, 1'h1};
        cases[2] = '{4'hF, 1'h1, 3'h7, 3'h0, 1'h0, 1'h1, 1'h1};
        cases[3] = '{4'h0, 1'h0, 3'h0, 3'h7, 1'h1, 1'h0, 1'h0};
        repeat (6) @(posedge SYS_CLK_I);
        #1 check({15'h0, STRAP_PHASE_O}, 16'h1);
        check(seen, 16'h0);
        @(posedge SYS_CLK_I);
        RST_I <= 1'h0;
        repeat (2) @(posedge SYS_CLK_I);
        #1 check({15'h0, CONFIG_VALID_O}, 16'h0);
        check(seen, expv(`BSL_CFG_RESET));
        for (int k = 0; k < 4; k++) begin
            capture(cases[k], k[0]);
        end
        // power-on reset held low masks device reset pulses
        @(posedge SYS_CLK_I);
        POR_N_I <= 1'h0;
        strap <= cases[0];
        repeat (2) @(posedge SYS_CLK_I);
        RESET_N_I <= 1'h0;
        repeat (2) @(posedge SYS_CLK_I);
        RESET_N_I <= 1'h1;
        repeat (3) @(posedge SYS_CLK_I);
        #1 check(seen, expv(cases[3]));
        @(posedge SYS_CLK_I);
        POR_N_I <= 1'h1;
        repeat (2) @(posedge SYS_CLK_I);
        #1 check(seen, expv(cases[0]));
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
